/* File: design/ptsl_pkg.sv */
// Package for the test, status and indicator register bank
package ptsl_pkg;

    // ****************************************************************
    // Register indices and byte address width
    // ****************************************************************
    localparam logic [7:0] IDX_ERR_TALLY = 8'h15;
    localparam logic [7:0] IDX_TEST_CTRL = 8'h16;
    localparam logic [7:0] IDX_STATUS2 = 8'h17;
    localparam logic [7:0] IDX_IND_SRC = 8'h18;
    localparam int ADDR_W = 10;

    // ****************************************************************
    // Reset values and field codes
    // ****************************************************************
    localparam logic [15:0] RST_ERR_TALLY = 16'h0000;
    localparam logic [15:0] RST_TEST_CTRL = 16'h0000;
    localparam logic [15:0] RST_STATUS2 = 16'h0040;
    localparam logic [3:0] RST_AUX_SRC = 4'h6;
    localparam logic [15:0] TALLY_MAX = 16'hffff;
    localparam logic [3:0] GEN_OFF = 4'h0;
    localparam logic [3:0] GEN_CONT = 4'hf;
    localparam logic [3:0] LOOP_NONE = 4'h0;
    localparam logic [3:0] LOOP_DIG = 4'h1;
    localparam logic [3:0] LOOP_ANA = 4'h2;
    localparam logic [3:0] LOOP_EXT = 4'h4;
    localparam logic [3:0] LOOP_REV = 4'h8;
    // Writable bits of the control word: 15-12 and 7-0, 9-8 kept as storage
    localparam logic [15:0] TEST_CTRL_WMASK = 16'hf3ff;

    // Indicator source codes
    localparam logic [3:0] SRC_LINK = 4'h0;
    localparam logic [3:0] SRC_ACT = 4'h1;
    localparam logic [3:0] SRC_TX = 4'h2;
    localparam logic [3:0] SRC_RX = 4'h3;
    localparam logic [3:0] SRC_COL = 4'h4;
    localparam logic [3:0] SRC_L1000 = 4'h5;
    localparam logic [3:0] SRC_L100 = 4'h6;
    localparam logic [3:0] SRC_L10 = 4'h7;
    localparam logic [3:0] SRC_L10_100 = 4'h8;
    localparam logic [3:0] SRC_L100_1000 = 4'h9;
    localparam logic [3:0] SRC_FDX = 4'ha;
    localparam logic [3:0] SRC_LINK_BLINK = 4'hb;
    localparam logic [3:0] SRC_ANY_ERR = 4'hd;
    localparam logic [3:0] SRC_RX_ERR = 4'he;

    // Copper loopback points decoded from the test control word
    typedef enum logic [2:0] {
        PTSL_LP_NONE = 3'h0,
        PTSL_LP_GIG_PRE_DSP = 3'h1,
        PTSL_LP_FE_PRE_SCR = 3'h2,
        PTSL_LP_FE_PRE_MLT = 3'h3,
        PTSL_LP_FE_FULL = 3'h4
    } ptsl_lpoint_t;

    // Events and levels observed from the PHY core
    typedef struct packed {
        logic rx_error;
        logic pd_found;
        logic pd_no_signal;
        logic pd_watchdog;
        logic pd_non_pd;
        logic checker_locked;
        logic checker_sync_lost;
        logic generator_running;
        logic gig_master_legacy;
        logic gig_slave_legacy;
        logic core_power_normal;
    } ptsl_phy_stat_t;

    // Controls presented to the data path
    typedef struct packed {
        logic prbs_enable;
        logic [3:0] loop_select;
        logic [1:0] pcs_loop_point;
        logic reverse_loop_rx_forward;
        logic mii_loop_tx_forward;
        ptsl_lpoint_t loop_point;
        logic [3:0] aux_indicator_source;
        logic [3:0] indicator2_source;
        logic [3:0] indicator1_source;
        logic [3:0] indicator0_source;
    } ptsl_ctrl_t;

endpackage

/* File: design/ptsl_regs.sv */
// APB register bank for self test, second status word and indicator sources
//
// Operation
// - Sixteen-bit error tally, write ones clears
// - Generator field: 0h off, Fh continuous
// - Bit 7 forwards receive data in reverse loop
// - Bit 6 forwards transmit data in MII loop
// - Bits 5-2 pick none/digital/analog/external/reverse loop
// - Gigabit: low bit set loops before DSP
// - 100M: 01 pre-scrambler, 10 pre-encoder, 11 full
// - Bits 15-12 detection results, clear on read
// - Bit 11 shows checker lock
// - Bit 10 latches sync loss, read clears
// - Bit 9 shows generator running
// - Bits 8, 7 show legacy scrambling
// - Bit 6 normal power; reset 0040h
// - Aux indicator source resets to 6h
// - Indicator source codes drive each indicator
// - Indicators 2-0 reset from pin straps
//
// Local design decision: the APB interface to the registers.
module ptsl_regs (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ptsl_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Pin straps for indicator sources 2..0, pins
    input wire logic [11:0] strap_ind_src_in,
    // Operating speed of the copper link
    input wire logic speed_gig_in,
    input wire logic speed_100_in,
    // Status from the PHY core, same clock
    input wire ptsl_pkg::ptsl_phy_stat_t phy_stat_in,
    // Indicator conditions, same clock
    input wire logic [15:0] ind_cond_in,
    // Controls and indicator outputs
    output ptsl_pkg::ptsl_ctrl_t ctrl_out,
    output logic [3:0] indicator_out
);

    // ****************************************************************
    // Strap synchroniser and capture after reset release
    // ****************************************************************
    logic [11:0] strap_s1;
    logic [11:0] strap_s2;
    logic strap_done;
    logic next_strap_done;

    // No reset here: the straps must settle through both stages while reset
    // is held, so the first edge after release already sees their levels
    always_ff @(posedge sys_clk_in) begin
        strap_s1 <= strap_ind_src_in;
        strap_s2 <= strap_s1;
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic acc;
    logic ack;
    logic load;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic mapped;
    logic wait_done;
    logic next_wait_done;

    always_comb begin
        acc = psel_in && penable_in;
        // Writes and read clears land on the ready edge only; read data is
        // latched one edge earlier so it stands while ready is high
        ack = acc && wait_done;
        load = acc && !wait_done && !pwrite_in;
        wr = ack && pwrite_in;
        rd = ack && !pwrite_in;
        idx = paddr_in[ptsl_pkg::ADDR_W-1:2];
        mapped = (paddr_in[1:0] == 2'h0) &&
            ((idx == ptsl_pkg::IDX_ERR_TALLY) || (idx == ptsl_pkg::IDX_TEST_CTRL) ||
             (idx == ptsl_pkg::IDX_STATUS2) || (idx == ptsl_pkg::IDX_IND_SRC));
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [15:0] tally;
    logic [15:0] next_tally;
    logic [15:0] tctl;
    logic [15:0] next_tctl;
    logic [3:0] pd_flags;
    logic [3:0] next_pd_flags;
    logic sync_lost;
    logic next_sync_lost;
    logic [15:0] isrc;
    logic [15:0] next_isrc;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [3:0] ev_pd;
    logic [15:0] status2;

    always_comb begin
        ev_pd = {phy_stat_in.pd_found, phy_stat_in.pd_no_signal,
                 phy_stat_in.pd_watchdog, phy_stat_in.pd_non_pd};
        status2 = {pd_flags, phy_stat_in.checker_locked, sync_lost,
                   phy_stat_in.generator_running, phy_stat_in.gig_master_legacy,
                   phy_stat_in.gig_slave_legacy, phy_stat_in.core_power_normal, 6'h00};
    end

    always_comb begin
        next_tally = tally;
        next_tctl = tctl;
        next_pd_flags = pd_flags;
        next_sync_lost = sync_lost;
        next_isrc = isrc;
        next_strap_done = 1'b1;
        next_rdata = 32'h0000_0000;
        if (!strap_done) begin
            next_isrc[11:0] = strap_s2;
        end
        if (wr && mapped && idx == ptsl_pkg::IDX_ERR_TALLY) begin
            next_tally = tally & ~pwdata_in[15:0];
        end
        // Holding at the top keeps a wrapped count from looking healthy
        // saturating count, event wins over clear
        if (phy_stat_in.rx_error) begin
            if (next_tally != ptsl_pkg::TALLY_MAX) begin
                next_tally = next_tally + 16'h0001;
            end
        end
        if (wr && mapped && idx == ptsl_pkg::IDX_TEST_CTRL) begin
            next_tctl = pwdata_in[15:0] & ptsl_pkg::TEST_CTRL_WMASK;
        end
        if (wr && mapped && idx == ptsl_pkg::IDX_IND_SRC) begin
            next_isrc = pwdata_in[15:0];
        end
        // clear on read, new event wins
        // Only bits that went out in the read word clear, so an event that
        // arrives after the word was latched is not lost
        if (rd && mapped && idx == ptsl_pkg::IDX_STATUS2) begin
            next_pd_flags = pd_flags & ~rdata[15:12];
            next_sync_lost = sync_lost && !rdata[10];
        end
        next_pd_flags = next_pd_flags | ev_pd;
        next_sync_lost = next_sync_lost | phy_stat_in.checker_sync_lost;
        if (load && mapped) begin
            case (idx)
                ptsl_pkg::IDX_ERR_TALLY: next_rdata = {16'h0000, tally};
                ptsl_pkg::IDX_TEST_CTRL: next_rdata = {16'h0000, tctl};
                ptsl_pkg::IDX_STATUS2: next_rdata = {16'h0000, status2};
                ptsl_pkg::IDX_IND_SRC: next_rdata = {16'h0000, isrc};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tally <= ptsl_pkg::RST_ERR_TALLY;
            tctl <= ptsl_pkg::RST_TEST_CTRL;
            pd_flags <= ptsl_pkg::RST_STATUS2[15:12];
            sync_lost <= ptsl_pkg::RST_STATUS2[10];
            isrc <= {ptsl_pkg::RST_AUX_SRC, 12'h000};
            strap_done <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            tally <= next_tally;
            tctl <= next_tctl;
            pd_flags <= next_pd_flags;
            sync_lost <= next_sync_lost;
            isrc <= next_isrc;
            strap_done <= next_strap_done;
            rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // APB answer: one wait state, data registered
    // ****************************************************************
    always_comb begin
        next_wait_done = acc && !wait_done;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wait_done <= 1'b0;
        end else begin
            wait_done <= next_wait_done;
        end
    end

    // Read side effects fire once: state changes only on the ready edge
    assign pready_out = wait_done;
    assign pslverr_out = wait_done && !mapped;
    assign prdata_out = rdata;

    // ****************************************************************
    // Control decode
    // ****************************************************************
    always_comb begin
        ctrl_out.prbs_enable = (tctl[15:12] == ptsl_pkg::GEN_CONT);
        ctrl_out.loop_select = tctl[5:2];
        ctrl_out.pcs_loop_point = tctl[1:0];
        // Stored as written; the loop gate keeps a stale bit from acting
        // forward only under reverse loop
        ctrl_out.reverse_loop_rx_forward = tctl[7] && (tctl[5:2] == ptsl_pkg::LOOP_REV);
        // forward only under loop other than none
        ctrl_out.mii_loop_tx_forward = tctl[6] && (tctl[5:2] != ptsl_pkg::LOOP_NONE);
        ctrl_out.loop_point = ptsl_pkg::PTSL_LP_NONE;
        // Gigabit wins when both speed levels are high and bit 0 is set; with bit 0 clear the 100M decode applies
        // loopback point decode
        if (speed_gig_in && tctl[0]) begin
            ctrl_out.loop_point = ptsl_pkg::PTSL_LP_GIG_PRE_DSP;
        end else if (speed_100_in) begin
            case (tctl[1:0])
                2'h1: ctrl_out.loop_point = ptsl_pkg::PTSL_LP_FE_PRE_SCR;
                2'h2: ctrl_out.loop_point = ptsl_pkg::PTSL_LP_FE_PRE_MLT;
                2'h3: ctrl_out.loop_point = ptsl_pkg::PTSL_LP_FE_FULL;
                default: ctrl_out.loop_point = ptsl_pkg::PTSL_LP_NONE;
            endcase
        end
        ctrl_out.aux_indicator_source = isrc[15:12];
        ctrl_out.indicator2_source = isrc[11:8];
        ctrl_out.indicator1_source = isrc[7:4];
        ctrl_out.indicator0_source = isrc[3:0];
    end

    // ****************************************************************
    // Indicator source mux, registered; every code, Ch and Fh included, picks that bit of ind_cond_in
    // ****************************************************************
    logic [3:0] ind;
    logic [3:0] next_ind;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ind
            always_comb begin
                next_ind[gi] = ind_cond_in[isrc[gi*4 +: 4]];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ind <= 4'h0;
        end else begin
            ind <= next_ind;
        end
    end

    assign indicator_out = ind;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_tally_clear: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr && mapped && idx == ptsl_pkg::IDX_ERR_TALLY && pwdata_in[15:0] == 16'hffff
         && !phy_stat_in.rx_error) |=> (tally == 16'h0000))
        else $error("tally not cleared by write of ones");
    a_tally_sat: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (tally == 16'hffff && !wr) |=> (tally == 16'hffff))
        else $error("tally wrapped");
    a_tally_count: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (phy_stat_in.rx_error && !wr && tally != 16'hffff) |=> (tally == $past(tally) + 16'h0001))
        else $error("tally missed an error");
    a_tally_hold: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (!phy_stat_in.rx_error && !wr) |=> (tally == $past(tally)))
        else $error("tally moved without an error");
    a_gen_enable: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr && mapped && idx == ptsl_pkg::IDX_TEST_CTRL && pwdata_in[15:12] == 4'hf)
        |=> ctrl_out.prbs_enable)
        else $error("generator enable wrong");
    a_rev_fwd: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        ctrl_out.reverse_loop_rx_forward |-> (tctl[5:2] == 4'h8))
        else $error("reverse forward outside reverse loop");
    a_sync_latch: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        phy_stat_in.checker_sync_lost |=> sync_lost)
        else $error("sync loss not latched");
    a_sync_hold: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (sync_lost && !(rd && mapped && idx == ptsl_pkg::IDX_STATUS2)) |=> sync_lost)
        else $error("sync loss dropped without a read");
    a_pd_read_clr: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (rd && mapped && idx == ptsl_pkg::IDX_STATUS2 && ev_pd == 4'h0)
        |=> ((pd_flags & $past(rdata[15:12])) == 4'h0))
        else $error("detect flags not cleared on read");
    a_pd_latch: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (ev_pd != 4'h0) |=> ((pd_flags & $past(ev_pd)) == $past(ev_pd)))
        else $error("detect event not latched");

    // ****************************************************************
    // Bus timing, read data, refused write and strap capture checks
    // ****************************************************************
    a_ready_wait: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        $rose(psel_in) |-> !pready_out ##1 !pready_out ##1 pready_out)
        else $error("ready timing wrong");
    a_ready_pulse: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        pready_out |=> !pready_out)
        else $error("ready held too long");
    a_err_ready: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        pslverr_out |-> pready_out)
        else $error("error without ready");
    a_read_upper: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        pready_out |-> (prdata_out[31:16] == 16'h0000))
        else $error("upper read half not zero");
    a_refused_wr: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr && !mapped) |=> ((tctl == $past(tctl)) && (isrc == $past(isrc))))
        else $error("refused write changed a register");
    a_strap_load: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (!strap_done && !wr) |=> (isrc[11:0] == $past(strap_s2)))
        else $error("straps not captured");

    // ****************************************************************
    // Control and indicator checks
    // ****************************************************************
    a_ctrl_reserved: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        tctl[11:10] == 2'h0)
        else $error("reserved control bits set");
    a_mii_fwd: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        ctrl_out.mii_loop_tx_forward |-> (tctl[5:2] != ptsl_pkg::LOOP_NONE))
        else $error("transmit forward outside a loop");
    a_rev_gate: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (tctl[7] && tctl[5:2] == ptsl_pkg::LOOP_REV) |-> ctrl_out.reverse_loop_rx_forward)
        else $error("reverse forward missing");
    a_gig_point: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (speed_gig_in && tctl[0]) |-> (ctrl_out.loop_point == ptsl_pkg::PTSL_LP_GIG_PRE_DSP))
        else $error("gigabit loop point wrong");
    a_fe_full: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (speed_100_in && !speed_gig_in && tctl[1:0] == 2'h3)
        |-> (ctrl_out.loop_point == ptsl_pkg::PTSL_LP_FE_FULL))
        else $error("full path loop point wrong");
    a_loop_none: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (!speed_gig_in && !speed_100_in) |-> (ctrl_out.loop_point == ptsl_pkg::PTSL_LP_NONE))
        else $error("loop point without copper speed");
    a_src_write: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (wr && mapped && idx == ptsl_pkg::IDX_IND_SRC) |=> (isrc == $past(pwdata_in[15:0])))
        else $error("source write lost");
    a_ind_follow: assert property (
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        1'b1 |=> ((indicator_out[0] == $past(ind_cond_in[isrc[3:0]]))
                  && (indicator_out[3] == $past(ind_cond_in[isrc[15:12]]))))
        else $error("indicator does not follow its source");

endmodule // ptsl_regs

/* File: tb/ptsl_regs_test.sv */
// Self-checking bench for the test, status and indicator register bank
module ptsl_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic g; logic f; logic [15:0] w; logic [15:0] r;
        logic [2:0] lp; logic [3:0] ls; logic p; logic rx; logic tx;
    } ptsl_row_t;
    localparam logic [9:0] A_TAL = {ptsl_pkg::IDX_ERR_TALLY, 2'b00};
    localparam logic [9:0] A_CTL = {ptsl_pkg::IDX_TEST_CTRL, 2'b00};
    localparam logic [9:0] A_ST2 = {ptsl_pkg::IDX_STATUS2, 2'b00};
    localparam logic [9:0] A_IND = {ptsl_pkg::IDX_IND_SRC, 2'b00};
    // Loop select rows keep the coding-layer point at zero
    // software keeps point zero
    localparam ptsl_row_t ROWS [14] = '{
        '{1'b0, 1'b0, 16'hf000, 16'hf000, 3'h0, 4'h0, 1'b1, 1'b0, 1'b0},
        '{1'b0, 1'b0, 16'h0c00, 16'h0000, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 16'h0300, 16'h0300, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 16'h00a0, 16'h00a0, 3'h0, 4'h8, 1'b0, 1'b1, 1'b0},
        '{1'b0, 1'b0, 16'h0060, 16'h0060, 3'h0, 4'h8, 1'b0, 1'b0, 1'b1},
        '{1'b0, 1'b0, 16'h0044, 16'h0044, 3'h0, 4'h1, 1'b0, 1'b0, 1'b1},
        '{1'b0, 1'b0, 16'h0088, 16'h0088, 3'h0, 4'h2, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 16'h0010, 16'h0010, 3'h0, 4'h4, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 16'h00c0, 16'h00c0, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b1, 16'h0003, 16'h0003, 3'h1, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b0, 16'h0002, 16'h0002, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b1, 16'h0001, 16'h0001, 3'h2, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b1, 16'h0002, 16'h0002, 3'h3, 4'h0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b1, 16'h0003, 16'h0003, 3'h4, 4'h0, 1'b0, 1'b0, 1'b0}};
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [9:0] paddr_in = 10'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [11:0] strap_ind_src_in = 12'h321;
    logic speed_gig_in = 1'b0;
    logic speed_100_in = 1'b0;
    ptsl_pkg::ptsl_phy_stat_t phy_stat_in = 11'h001;
    logic [15:0] ind_cond_in = 16'h0000;
    ptsl_pkg::ptsl_ctrl_t ctrl_out;
    logic [3:0] indicator_out;
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic er;

    ptsl_regs DUT (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .strap_ind_src_in(strap_ind_src_in),
        .speed_gig_in(speed_gig_in), .speed_100_in(speed_100_in), .phy_stat_in(phy_stat_in),
        .ind_cond_in(ind_cond_in), .ctrl_out(ctrl_out), .indicator_out(indicator_out));

    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
            err_total++;
        end
    endtask

    // Request held until the rising edge that sees pready high
    task automatic apb(input logic wr, input logic [9:0] a, input logic [15:0] wd,
                       output logic [31:0] d, output logic e);
        int i;
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= {16'h0, wd};
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_in);
            if (pready_out === 1'b1) break;
        end
        if (i == 20) begin
            $display("CHECK FAILED pready expected 1 seen timeout");
            err_total++;
            stop_test();
        end
        d = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
        chk("write err", 32'h0, {31'h0, e});
    endtask

    task automatic rdchk(input string nm, input logic [9:0] a, input logic [15:0] ex);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 16'h0, d, e);
        chk(nm, {16'h0, ex}, d);
        chk("read err", 32'h0, {31'h0, e});
    endtask

    task automatic reset_values(input logic [15:0] ind);
        rdchk("tally", A_TAL, 16'h0000);
        rdchk("control", A_CTL, 16'h0000);
        rdchk("status2", A_ST2, 16'h0040);
        rdchk("sources", A_IND, ind);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_values(16'h6321);
        $display("Test reset values done");
        foreach (ROWS[k]) begin
            speed_gig_in <= ROWS[k].g;
            speed_100_in <= ROWS[k].f;
            wr(A_CTL, ROWS[k].w);
            @(negedge sys_clk_in);
            chk("ctrl", {22'h0, ROWS[k].lp, ROWS[k].ls, ROWS[k].p, ROWS[k].rx, ROWS[k].tx},
                {22'h0, ctrl_out.loop_point, ctrl_out.loop_select, ctrl_out.prbs_enable,
                 ctrl_out.reverse_loop_rx_forward, ctrl_out.mii_loop_tx_forward});
            rdchk("control", A_CTL, ROWS[k].r);
        end
        $display("Test control rows done");
        // Every source code on all four indicators at once
        for (int c = 0; c < 15; c++) begin
            if (c == 12) continue;
            wr(A_IND, {4{c[3:0]}});
            ind_cond_in <= 16'h1 << c;
            repeat (2) @(posedge sys_clk_in);
            @(negedge sys_clk_in);
            chk("indicator on", 32'hf, {28'h0, indicator_out});
            ind_cond_in <= ~(16'h1 << c) & 16'h6fff;
            repeat (2) @(posedge sys_clk_in);
            @(negedge sys_clk_in);
            chk("indicator off", 32'h0, {28'h0, indicator_out});
        end
        wr(A_IND, 16'ha430);
        ind_cond_in <= 16'h0408;
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk("indicator mix", 32'ha, {28'h0, indicator_out});
        rdchk("sources", A_IND, 16'ha430);
        $display("Test indicator codes done");
        // Refused places leave the bank untouched
        apb(1'b0, 10'h064, 16'h0, rd, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, A_IND | 10'h001, 16'hffff, rd, er);
        chk("unaligned err", 32'h1, {31'h0, er});
        rdchk("sources", A_IND, 16'ha430);
        $display("Test refused access done");
        // Live levels and latched events
        @(posedge sys_clk_in);
        // One-cycle pulse of every status event except rx_error, then levels only
        phy_stat_in <= 11'h3fd;
        @(posedge sys_clk_in);
        phy_stat_in <= 11'h02d;
        rdchk("status2", A_ST2, 16'hff40);
        rdchk("status2", A_ST2, 16'h0b40);
        phy_stat_in <= 11'h002;
        rdchk("status2", A_ST2, 16'h0080);
        phy_stat_in <= 11'h001;
        $display("Test status word done");
        // Tally counts, clears by ones, saturates
        repeat (3) begin
            @(posedge sys_clk_in);
            phy_stat_in.rx_error <= 1'b1;
            @(posedge sys_clk_in);
            phy_stat_in.rx_error <= 1'b0;
        end
        rdchk("tally", A_TAL, 16'h0003);
        wr(A_TAL, 16'h0001);
        rdchk("tally", A_TAL, 16'h0002);
        @(posedge sys_clk_in);
        phy_stat_in.rx_error <= 1'b1;
        repeat (65540) @(posedge sys_clk_in);
        phy_stat_in.rx_error <= 1'b0;
        rdchk("tally", A_TAL, 16'hffff);
        wr(A_TAL, 16'hffff);
        rdchk("tally", A_TAL, 16'h0000);
        $display("Test error tally done");
        // Second reset picks up new strap levels
        wr(A_CTL, 16'hf0a0);
        strap_ind_src_in <= 12'h789;
        repeat (3) @(posedge sys_clk_in);
        arst_n_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_values(16'h6789);
        $display("Test second reset done");
        stop_test();
    end
endmodule // ptsl_regs_test
